// ---- design/czc_ctrl.sv ----
// charger input droop regulation loop and battery temperature-zone control
// assumes comparator flags are asynchronous; the register port is on clk
`timescale 1ns/1ps

module czc_ctrl
  import czc_pkg::*;
#(
  parameter int STEP_CYCLES     = CZC_STEP_CYCLES,
  parameter int DEBOUNCE_CYCLES = CZC_DEBOUNCE_CYCLES,
  parameter int LIMIT_W         = 4
) (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic [7:0]          reg_addr,
  input  wire logic                reg_wr,
  input  wire logic [7:0]          reg_wdata,
  output logic      [7:0]          reg_rdata,
  input  wire logic                above_threshold_cmp,
  input  wire logic                droop_cmp,
  input  wire czc_therm_t          therm_cmp,
  output logic      [LIMIT_W-1:0]  input_limit_step,
  output logic                     force_min_current,
  output logic      [9:0]          input_reg_threshold_10mv,
  output logic      [9:0]          droop_threshold_10mv,
  output logic                     droop_irq,
  output logic                     zone_irq,
  output czc_zone_t                zone,
  output czc_zone_out_t            zone_ctrl,
  output logic                     foldback_enable,
  output logic      [7:0]          die_temp_setpoint_c,
  output logic      [7:0]          hot_threshold_c,
  output logic      [7:0]          cold_threshold_c,
  output logic      [1:0]          precharge_deadbatt_threshold
);

  localparam logic [LIMIT_W-1:0] LIMIT_MAX = '1;
  localparam logic [31:0] STEP_LAST = 32'(STEP_CYCLES - 1);
  localparam logic [31:0] DEB_LAST  = 32'(DEBOUNCE_CYCLES - 1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]         temp_ctrl;
    logic [7:0]         input_reg;
    logic [7:0]         zone_adj;
    logic [1:0]         above_sync;
    logic [1:0]         droop_sync;
    czc_therm_t         therm_s1;
    czc_therm_t         therm_s2;
    czc_loop_t          loop;
    logic [LIMIT_W-1:0] limit;
    logic               forced;
    logic [31:0]        step_cnt;
    logic [31:0]        deb_cnt;
    logic               deb_done;
    logic               droop_irq;
    czc_zone_t          zone;
    logic               zone_irq;
    logic [7:0]         rdata;
  } czc_state_t;

  czc_state_t s_reg;
  czc_state_t s_next;

  logic       above_s;
  logic       droop_s;
  logic       loop_off;
  logic [1:0] cfg;
  czc_zone_t  zone_now;

  assign above_s  = s_reg.above_sync[1];
  assign droop_s  = s_reg.droop_sync[1];
  assign loop_off = s_reg.input_reg[CZC_IR_DISABLE_BIT];
  assign cfg      = s_reg.temp_ctrl[CZC_TC_CFG_LSB +: 2];

  // ----------------------------------------------------------------
  // zone decode from synchronised flags, hot and cold first
  // ----------------------------------------------------------------
  always_comb begin
    if (s_reg.therm_s2.hot) begin
      zone_now = CZC_ZONE_HOT;
    end else if (s_reg.therm_s2.cold) begin
      zone_now = CZC_ZONE_COLD;
    end else if (s_reg.therm_s2.warm) begin
      zone_now = CZC_ZONE_WARM;
    end else if (s_reg.therm_s2.cool) begin
      zone_now = CZC_ZONE_COOL;
    end else begin
      zone_now = CZC_ZONE_NORMAL;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.above_sync = {s_reg.above_sync[0], above_threshold_cmp};
    s_next.droop_sync = {s_reg.droop_sync[0], droop_cmp};
    s_next.therm_s1   = therm_cmp;
    s_next.therm_s2   = s_reg.therm_s1;
    s_next.droop_irq  = 1'b0;
    s_next.zone_irq   = 1'b0;

    // register writes; reserved bits stay zero
    if (reg_wr) begin
      if (reg_addr == CZC_ADDR_TEMP_CTRL) begin
        s_next.temp_ctrl = reg_wdata & CZC_MASK_TEMP_CTRL;
      end else if (reg_addr == CZC_ADDR_INPUT_REG) begin
        s_next.input_reg = reg_wdata & CZC_MASK_INPUT_REG;
      end else if (reg_addr == CZC_ADDR_ZONE_ADJ) begin
        s_next.zone_adj = reg_wdata & CZC_MASK_ZONE_ADJ;
      end
    end

    // registered read data; unmapped addresses read zero
    if (reg_addr == CZC_ADDR_TEMP_CTRL) begin
      s_next.rdata = s_reg.temp_ctrl;
    end else if (reg_addr == CZC_ADDR_INPUT_REG) begin
      s_next.rdata = s_reg.input_reg;
    end else if (reg_addr == CZC_ADDR_ZONE_ADJ) begin
      s_next.rdata = s_reg.zone_adj;
    end else begin
      s_next.rdata = 8'h00;
    end

    // droop loop: the disable bit wins over everything, then deep droop wins over tracking
    if (loop_off) begin
      s_next.loop     = CZC_LOOP_IDLE;
      s_next.limit    = LIMIT_MAX;
      s_next.forced   = 1'b0;
      s_next.step_cnt = '0;
    end else if (droop_s) begin
      s_next.loop     = CZC_LOOP_RAMP;
      s_next.limit    = '0;
      s_next.forced   = 1'b1;
      s_next.step_cnt = '0;
    end else begin
      case (s_reg.loop)
        CZC_LOOP_IDLE: begin
          if (!above_s) begin
            s_next.loop     = CZC_LOOP_TRACK;
            s_next.step_cnt = '0;
          end
        end
        CZC_LOOP_TRACK, CZC_LOOP_RAMP: begin
          // one step per period: down while below threshold (track only, ramp holds), up while above
          if (s_reg.step_cnt >= STEP_LAST) begin
            s_next.step_cnt = '0;
            if (above_s) begin
              s_next.forced = 1'b0;
              if (s_reg.limit != LIMIT_MAX) begin
                s_next.limit = s_reg.limit + 1'b1;
              end else begin
                s_next.loop = CZC_LOOP_IDLE;
              end
            end else if (s_reg.loop == CZC_LOOP_TRACK && s_reg.limit != '0) begin
              s_next.limit = s_reg.limit - 1'b1;
            end
          end else begin
            s_next.step_cnt = s_reg.step_cnt + 32'd1;
          end
        end
        default: s_next.loop = CZC_LOOP_IDLE;
      endcase
    end

    // debounce the regulation-active condition before interrupting
    if (s_reg.loop != CZC_LOOP_IDLE && !loop_off) begin
      if (!s_reg.deb_done) begin
        if (s_reg.deb_cnt >= DEB_LAST) begin
          s_next.deb_done  = 1'b1;
          s_next.droop_irq = 1'b1;
        end else begin
          s_next.deb_cnt = s_reg.deb_cnt + 32'd1;
        end
      end
    end else begin
      s_next.deb_cnt  = '0;
      s_next.deb_done = 1'b0;
    end

    // zone tracking and crossing interrupt for software mode
    s_next.zone = zone_now;
    if (cfg == CZC_CFG_SOFTWARE && zone_now != s_reg.zone) begin
      if (zone_now == CZC_ZONE_COOL || zone_now == CZC_ZONE_WARM
          || s_reg.zone == CZC_ZONE_COOL || s_reg.zone == CZC_ZONE_WARM) begin
        s_next.zone_irq = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_reg           <= '0;
      s_reg.temp_ctrl <= CZC_RST_TEMP_CTRL;
      s_reg.input_reg <= CZC_RST_INPUT_REG;
      s_reg.zone_adj  <= CZC_RST_ZONE_ADJ;
      s_reg.loop      <= CZC_LOOP_IDLE;
      s_reg.limit     <= LIMIT_MAX;
      s_reg.zone      <= CZC_ZONE_NORMAL;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic [1:0] cc_code;
  logic [1:0] cv_code;
  logic       zone_adj;
  assign cc_code  = s_reg.zone_adj[CZC_ZA_CC_LSB +: 2];
  assign cv_code  = s_reg.zone_adj[CZC_ZA_CV_LSB +: 2];
  assign zone_adj = (s_reg.zone == CZC_ZONE_COOL) || (s_reg.zone == CZC_ZONE_WARM);

  always_comb begin
    zone_ctrl = '0;
    // config 0 ignores the thermistor; config 1 still inhibits hot/cold and leaves cool/warm to software
    if (cfg != CZC_CFG_UNUSED) begin
      zone_ctrl.inhibit = (s_reg.zone == CZC_ZONE_COLD)
                          || (s_reg.zone == CZC_ZONE_HOT);
    end
    if (zone_adj && (cfg == CZC_CFG_CC_CV || cfg == CZC_CFG_CC_ONLY)) begin
      zone_ctrl.cc_adjust_on = 1'b1;
      zone_ctrl.cc_percent   = CZC_CHARGE_CURRENT_ADJUST_PCT[cc_code];
    end
    if (zone_adj && cfg == CZC_CFG_CC_CV) begin
      zone_ctrl.cv_adjust_on = 1'b1;
      zone_ctrl.cv_reduce_mv = CZC_CHARGE_VOLTAGE_ADJUST_MV[cv_code];
    end
  end

  assign reg_rdata         = s_reg.rdata;
  assign input_limit_step  = s_reg.limit;
  assign force_min_current = s_reg.forced;
  assign input_reg_threshold_10mv = CZC_THR_BASE_10MV
    + 10'(s_reg.input_reg[CZC_IR_THR_LSB +: 3]) * CZC_THR_STEP_10MV;
  assign droop_threshold_10mv = input_reg_threshold_10mv - CZC_DROOP_OFS_10MV;
  assign droop_irq        = s_reg.droop_irq;
  assign zone_irq         = s_reg.zone_irq;
  assign zone             = s_reg.zone;
  assign foldback_enable  = s_reg.temp_ctrl[CZC_TC_FOLDBACK_BIT];
  assign die_temp_setpoint_c = CZC_DIE_SP_C[s_reg.temp_ctrl[CZC_TC_DIE_SP_LSB +: 2]];
  assign hot_threshold_c  = CZC_HOT_C[s_reg.temp_ctrl[CZC_TC_HOT_SEL_BIT]];
  assign cold_threshold_c = CZC_COLD_C[s_reg.temp_ctrl[CZC_TC_COLD_SEL_BIT]];
  assign precharge_deadbatt_threshold = s_reg.input_reg[CZC_IR_DEADBATT_LSB +: 2];

endmodule

// ---- shared/czc_pkg.sv ----
// charger droop-loop and battery-zone control: shared constants and types
// assumes an 8-bit register port with address, write strobe and read data
package czc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CZC_ADDR_TEMP_CTRL  = 8'h92;
  localparam logic [7:0] CZC_ADDR_INPUT_REG  = 8'h95;
  localparam logic [7:0] CZC_ADDR_ZONE_ADJ   = 8'h9a;
  localparam logic [7:0] CZC_RST_TEMP_CTRL   = 8'h05;
  localparam logic [7:0] CZC_RST_INPUT_REG   = 8'h00;
  localparam logic [7:0] CZC_RST_ZONE_ADJ    = 8'h00;
  localparam logic [7:0] CZC_MASK_TEMP_CTRL  = 8'hbf;
  localparam logic [7:0] CZC_MASK_INPUT_REG  = 8'h3f;
  localparam logic [7:0] CZC_MASK_ZONE_ADJ   = 8'h3f;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CZC_TC_FOLDBACK_BIT  = 7;
  localparam int CZC_TC_HOT_SEL_BIT   = 5;
  localparam int CZC_TC_COLD_SEL_BIT  = 4;
  localparam int CZC_TC_DIE_SP_LSB    = 2;
  localparam int CZC_TC_CFG_LSB       = 0;
  localparam int CZC_IR_DISABLE_BIT   = 5;
  localparam int CZC_IR_DEADBATT_LSB  = 3;
  localparam int CZC_IR_THR_LSB       = 0;
  localparam int CZC_ZA_CC_LSB        = 4;
  localparam int CZC_ZA_CV_LSB        = 2;
  localparam int CZC_ZA_COOL_SEL_BIT  = 1;
  localparam int CZC_ZA_WARM_SEL_BIT  = 0;

  // ----------------------------------------------------------------
  // encodings and figures (thresholds in 10 mV units)
  // ----------------------------------------------------------------
  localparam logic [1:0] CZC_CFG_UNUSED   = 2'h0;
  localparam logic [1:0] CZC_CFG_SOFTWARE = 2'h1;
  localparam logic [1:0] CZC_CFG_CC_CV    = 2'h2;
  localparam logic [1:0] CZC_CFG_CC_ONLY  = 2'h3;
  localparam logic [9:0] CZC_THR_BASE_10MV = 10'h186;  // 3.9 V
  localparam logic [9:0] CZC_THR_STEP_10MV = 10'h00a;  // 0.1 V
  localparam logic [9:0] CZC_DROOP_OFS_10MV = 10'h014; // 200 mV
  localparam logic [7:0] CZC_CHARGE_VOLTAGE_ADJUST_MV [4] = '{8'h3c, 8'h64, 8'ha0, 8'hc8};
  localparam logic [6:0] CZC_CHARGE_CURRENT_ADJUST_PCT [4] = '{7'h19, 7'h32, 7'h4b, 7'h64};
  localparam logic [7:0] CZC_DIE_SP_C [4] = '{8'h50, 8'h5f, 8'h6e, 8'h00};
  localparam logic [7:0] CZC_HOT_C [2]  = '{8'h3c, 8'h37};
  localparam logic [7:0] CZC_COLD_C [2] = '{8'h00, 8'hf6};

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CZC_CLK_HZ      = 250_000_000;
  localparam int CZC_STEP_MS     = 10;
  localparam int CZC_STEP_CYCLES = CZC_CLK_HZ / 1000 * CZC_STEP_MS;
  localparam int CZC_DEBOUNCE_US = 10;
  localparam int CZC_DEBOUNCE_CYCLES = CZC_CLK_HZ / 1_000_000 * CZC_DEBOUNCE_US;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    CZC_ZONE_NORMAL = 5'b00001,
    CZC_ZONE_COLD   = 5'b00010,
    CZC_ZONE_COOL   = 5'b00100,
    CZC_ZONE_WARM   = 5'b01000,
    CZC_ZONE_HOT    = 5'b10000
  } czc_zone_t;

  typedef enum logic [2:0] {
    CZC_LOOP_IDLE  = 3'b001,
    CZC_LOOP_TRACK = 3'b010,
    CZC_LOOP_RAMP  = 3'b100
  } czc_loop_t;

  typedef struct packed {
    logic cold;
    logic cool;
    logic warm;
    logic hot;
  } czc_therm_t;

  typedef struct packed {
    logic       inhibit;
    logic       cc_adjust_on;
    logic [6:0] cc_percent;
    logic       cv_adjust_on;
    logic [7:0] cv_reduce_mv;
  } czc_zone_out_t;

endpackage

// ---- verif/czc_ctrl_asserts.sv ----
// assertions on czc_ctrl ports: threshold decode, droop loop, zones
// assumes bind into czc_ctrl; writes to 0x92/0x95 are mirrored here
`timescale 1ns/1ps
module czc_ctrl_asserts
  import czc_pkg::*;
#(
  parameter int STEP_CYCLES = 20,
  parameter int LIMIT_W     = 4
) (
  input wire logic               clk,
  input wire logic               sys_rst,
  input wire logic [7:0]         reg_addr,
  input wire logic               reg_wr,
  input wire logic [7:0]         reg_wdata,
  input wire logic               droop_cmp,
  input wire czc_therm_t         therm_cmp,
  input wire logic [LIMIT_W-1:0] input_limit_step,
  input wire logic               force_min_current,
  input wire logic [9:0]         input_reg_threshold_10mv,
  input wire logic [9:0]         droop_threshold_10mv,
  input wire logic               droop_irq,
  input wire logic               zone_irq,
  input wire czc_zone_t          zone,
  input wire czc_zone_out_t      zone_ctrl
);
  // ------------------------------
  // mode mirror and step spacing
  // ------------------------------
  logic [1:0]         cfg_reg;
  logic [2:0]         code_reg;
  logic               dis_reg;
  logic [LIMIT_W-1:0] last_reg;
  int                 quiet_reg;
  logic               cw;
  logic               hc;
  assign cw = zone == CZC_ZONE_COOL || zone == CZC_ZONE_WARM;
  assign hc = zone == CZC_ZONE_COLD || zone == CZC_ZONE_HOT;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_reg   <= 2'h1;
      code_reg  <= 3'h0;
      dis_reg   <= 1'b0;
      last_reg  <= '1;
      quiet_reg <= 0;
    end else begin
      if (reg_wr && reg_addr == CZC_ADDR_TEMP_CTRL) cfg_reg <= reg_wdata[1:0];
      if (reg_wr && reg_addr == CZC_ADDR_INPUT_REG) dis_reg <= reg_wdata[5];
      if (reg_wr && reg_addr == CZC_ADDR_INPUT_REG) code_reg <= reg_wdata[2:0];
      last_reg  <= input_limit_step;
      // only a loose floor: the exact step phase is the design's choice
      quiet_reg <= (input_limit_step != last_reg) ? 0 : quiet_reg + 1;
    end
  end

  function automatic czc_zone_t zone_of(czc_therm_t f);
    if (f.hot) return CZC_ZONE_HOT;
    if (f.cold) return CZC_ZONE_COLD;
    if (f.warm) return CZC_ZONE_WARM;
    if (f.cool) return CZC_ZONE_COOL;
    return CZC_ZONE_NORMAL;
  endfunction

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence droop_held_s;
    droop_cmp [*3];
  endsequence
  sequence cut_seen_s;
    ##[0:1] (input_limit_step == '0 && force_min_current);
  endsequence

  thr_code_a: assert property (
    input_reg_threshold_10mv == CZC_THR_BASE_10MV + CZC_THR_STEP_10MV * code_reg)
    else $error("threshold does not follow code");
  droop_ofs_a: assert property (
    droop_threshold_10mv + CZC_DROOP_OFS_10MV == input_reg_threshold_10mv)
    else $error("droop threshold offset wrong");
  droop_cut_a: assert property (disable iff (sys_rst || dis_reg)
    droop_held_s |=> cut_seen_s) else $error("no forced cut on droop");
  step_one_a: assert property (disable iff (sys_rst || dis_reg)
    input_limit_step > $past(input_limit_step) |->
    input_limit_step == $past(input_limit_step) + 1'b1) else $error("step above one");
  step_rate_a: assert property (disable iff (sys_rst || dis_reg)
    input_limit_step > $past(input_limit_step) |-> quiet_reg >= STEP_CYCLES / 2)
    else $error("step too soon");
  force_rise_a: assert property ($rose(force_min_current) |-> input_limit_step == '0)
    else $error("forced flag without minimum");
  force_fall_a: assert property (disable iff (sys_rst || dis_reg)
    $fell(force_min_current) |-> input_limit_step == 1'b1) else $error("bad first step");
  irq_pulse_a: assert property (droop_irq |-> !$past(dis_reg) ##1 !droop_irq)
    else $error("droop interrupt not a single pulse");
  zone_track_a: assert property ($stable(therm_cmp) [*5] |-> zone == zone_of(therm_cmp))
    else $error("zone does not follow flags");
  inhibit_a: assert property (
    zone_ctrl.inhibit == (cfg_reg != CZC_CFG_UNUSED && hc)) else $error("inhibit wrong");
  adjust_on_a: assert property (
    zone_ctrl.cc_adjust_on == (cfg_reg[1] && cw) &&
    zone_ctrl.cv_adjust_on == (cfg_reg == CZC_CFG_CC_CV && cw)) else $error("adjust wrong");
  zone_irq_a: assert property (zone_irq |-> $past(cfg_reg) == CZC_CFG_SOFTWARE)
    else $error("zone interrupt outside software mode");
endmodule

// ---- verif/czc_far_model.sv ----
// supply and thermistor comparators facing czc_ctrl
// assumes thresholds come from the block's decoded register outputs
`timescale 1ns/1ps
module czc_far_model
  import czc_pkg::*;
#(
  parameter int COOL_C = 10,
  parameter int WARM_C = 45
) (
  input  wire logic        [9:0] vbus_10mv,
  input  wire logic signed [7:0] temp_c,
  input  wire logic        [9:0] input_reg_threshold_10mv,
  input  wire logic        [9:0] droop_threshold_10mv,
  input  wire logic        [7:0] hot_threshold_c,
  input  wire logic        [7:0] cold_threshold_c,
  output czc_therm_t             therm_cmp,
  output logic                   above_threshold_cmp,
  output logic                   droop_cmp
);
  // ------------------------------
  // comparators
  // ------------------------------
  // analog, so no clock; an unknown threshold reads as not tripped
  assign above_threshold_cmp = (vbus_10mv > input_reg_threshold_10mv) === 1'b1;
  assign droop_cmp           = (vbus_10mv < droop_threshold_10mv) === 1'b1;
  assign therm_cmp           = {(temp_c <= $signed(cold_threshold_c)) === 1'b1,
                                temp_c < COOL_C, temp_c > WARM_C,
                                (temp_c >= $signed(hot_threshold_c)) === 1'b1};
endmodule

// ---- verif/tb.sv ----
// testbench: register access, droop loop and battery zones of czc_ctrl
// assumes czc_far_model turns vbus and temperature into comparator flags
`timescale 1ns/1ps
`define CHK(g, e) begin \
  checks++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("Error t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
module tb
  import czc_pkg::*;
;
  // ------------------------------
  // signals and instances
  // ------------------------------
  logic              clk, sys_rst, reg_wr, above_threshold_cmp, droop_cmp;
  logic [7:0]        reg_addr, reg_wdata, reg_rdata, hot_threshold_c, cold_threshold_c;
  logic [9:0]        vbus_10mv, input_reg_threshold_10mv, droop_threshold_10mv;
  logic signed [7:0] temp_c;
  logic [3:0]        input_limit_step;
  logic              force_min_current, droop_irq, zone_irq, foldback_enable;
  logic [7:0]        die_temp_setpoint_c;
  logic [1:0]        precharge_deadbatt_threshold;
  czc_therm_t        therm_cmp;
  czc_zone_t         zone;
  czc_zone_out_t     zone_ctrl;
  int                n_errors, checks, zirq_n, dirq_n;
  logic signed [7:0] tz [5] = '{8'shec, 8'sh05, 8'sh19, 8'sh32, 8'sh46};
  czc_zone_t         ze [5] = '{CZC_ZONE_COLD, CZC_ZONE_COOL, CZC_ZONE_NORMAL,
                                CZC_ZONE_WARM, CZC_ZONE_HOT};

  czc_ctrl #(.STEP_CYCLES(20), .DEBOUNCE_CYCLES(8), .LIMIT_W(4)) czc_ctrl_i (
    .clk, .sys_rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .above_threshold_cmp,
    .droop_cmp, .therm_cmp, .input_limit_step, .force_min_current, .input_reg_threshold_10mv,
    .droop_threshold_10mv, .droop_irq, .zone_irq, .zone, .zone_ctrl, .foldback_enable,
    .die_temp_setpoint_c, .hot_threshold_c, .cold_threshold_c, .precharge_deadbatt_threshold);
  czc_far_model czc_far_model_i (.vbus_10mv, .temp_c, .input_reg_threshold_10mv,
    .droop_threshold_10mv, .hot_threshold_c, .cold_threshold_c, .therm_cmp,
    .above_threshold_cmp, .droop_cmp);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (zone_irq === 1'b1) zirq_n++;
    if (droop_irq === 1'b1) dirq_n++;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    reg_addr = a;
    repeat (2) @(negedge clk);
    `CHK(reg_rdata, e)
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wait_lim(input logic [3:0] v);
    for (int i = 0; i < 2000 && input_limit_step !== v; i++) @(negedge clk);
    `CHK(input_limit_step, v)
    if (input_limit_step !== v) print_verdict();
  endtask

  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    logic [1:0] k;
    static logic [7:0] die [4] = '{8'h50, 8'h5f, 8'h6e, 8'h00};
    static logic [6:0] pct [4] = '{7'h19, 7'h32, 7'h4b, 7'h64};
    static logic [7:0] mv [4] = '{8'h3c, 8'h64, 8'ha0, 8'hc8};
    {sys_rst, reg_wr, reg_addr, reg_wdata} = {1'b1, 1'b0, 8'h00, 8'h00};
    vbus_10mv = 10'h1f4;
    temp_c = 8'sh19;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    rd(8'h92, 8'h05);
    rd(8'h95, 8'h00);
    rd(8'h9a, 8'h00);
    wr(8'h93, 8'hff);
    rd(8'h93, 8'h00);
    wr(8'h95, 8'hff);
    rd(8'h95, 8'h3f);
    wr(8'h9a, 8'hff);
    rd(8'h9a, 8'h3f);
    wr(8'h92, 8'hff);
    rd(8'h92, 8'hbf);
    for (int i = 0; i < 8; i++) begin
      wr(8'h95, 8'((i % 4) * 8 + i));
      `CHK(input_reg_threshold_10mv, 10'(10'h186 + 10'h00a * i))
      `CHK(droop_threshold_10mv, 10'(10'h172 + 10'h00a * i))
      `CHK(precharge_deadbatt_threshold, 2'(i))
    end
    for (int i = 0; i < 4; i++) begin
      k = 2'(i);
      wr(8'h92, {k[0], 1'b0, k[0], k[1], k, 2'h2});
      `CHK(foldback_enable, k[0])
      `CHK(die_temp_setpoint_c, die[k])
      `CHK(hot_threshold_c, k[0] ? 8'h37 : 8'h3c)
      `CHK(cold_threshold_c, k[1] ? 8'hf6 : 8'h00)
    end
    zirq_n = 0;
    for (int c = 0; c < 4; c++) begin
      wr(8'h92, 8'(c));
      for (int z = 0; z < 5; z++) begin
        temp_c = tz[z];
        repeat (6) @(negedge clk);
        `CHK(zone, ze[z])
        `CHK(zone_ctrl.inhibit, c != 0 && (z == 0 || z == 4))
        `CHK(zone_ctrl.cc_adjust_on, c > 1 && (z == 1 || z == 3))
        `CHK(zone_ctrl.cv_adjust_on, c == 2 && (z == 1 || z == 3))
      end
    end
    `CHK(zirq_n, 4)
    wr(8'h92, 8'h02);
    temp_c = 8'sh05;
    // flags need three edges to reach the zone register
    repeat (4) @(negedge clk);
    for (int i = 0; i < 4; i++) begin
      k = 2'(i);
      wr(8'h9a, {2'h0, k, k, 2'h0});
      `CHK(zone_ctrl.cc_percent, pct[k])
      `CHK(zone_ctrl.cv_reduce_mv, mv[k])
    end
    wr(8'h95, 8'h06);
    vbus_10mv = 10'h1a4;
    wait_lim(4'h0);
    `CHK(force_min_current, 1'b1)
    vbus_10mv = 10'h1c7;
    wait_lim(4'h1);
    `CHK(force_min_current, 1'b0)
    vbus_10mv = 10'h1bd;
    // three full step periods with the input below threshold
    repeat (60) @(negedge clk);
    `CHK(input_limit_step, 4'h1)
    vbus_10mv = 10'h1cc;
    wait_lim(4'hf);
    `CHK(dirq_n > 0, 1'b1)
    // ramp only holds when below; stay above one more period so the loop idles
    repeat (25) @(negedge clk);
    vbus_10mv = 10'h1bd;
    wait_lim(4'he);
    wr(8'h95, 8'h26);
    vbus_10mv = 10'h1a4;
    repeat (10) @(negedge clk);
    `CHK(input_limit_step, 4'hf)
    `CHK(force_min_current, 1'b0)
    print_verdict();
  end
endmodule

bind czc_ctrl czc_ctrl_asserts #(.STEP_CYCLES(STEP_CYCLES), .LIMIT_W(LIMIT_W))
  czc_ctrl_asserts_i (.clk, .sys_rst, .reg_addr, .reg_wr, .reg_wdata, .droop_cmp,
  .therm_cmp, .input_limit_step, .force_min_current, .input_reg_threshold_10mv,
  .droop_threshold_10mv, .droop_irq, .zone_irq, .zone, .zone_ctrl);
